// ===== rtl/sbp_pkg.sv
package sbp_pkg;
  // ************************************************************
  // timing figures and cycle counts
  // ************************************************************
  localparam int CLK_PERIOD_PS   = 8000;
  localparam int SETTLE_NS       = 400;
  localparam int CLEAR_NS        = 800;
  localparam int FREE_NS         = 800;
  localparam int SET_NS          = 1800;
  localparam int ARB_NS          = 2400;
  localparam int DESKEW_NS       = 400;
  localparam int ABORT_US        = 200;
  // minimum waits round up, maxima round down
  localparam int SETTLE_CYC      = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FREE_CYC        = (FREE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ARB_CYC         = (ARB_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DESKEW_CYC      = (DESKEW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CLEAR_CYC       = (CLEAR_NS * 1000) / CLK_PERIOD_PS;
  localparam int SET_CYC         = (SET_NS * 1000) / CLK_PERIOD_PS;
  localparam int ABORT_CYC       = (ABORT_US * 1000000) / CLK_PERIOD_PS;
  // winner holds for a clear plus a settle delay
  localparam int HOLD_CYC        = CLEAR_CYC + SETTLE_CYC;
  localparam int CNT_W           = 16;
  localparam int ID_W            = 3;
  localparam int DB_W            = 8;
  localparam int SYNC_W          = 5;
  // synchroniser vector layout
  localparam int SY_BSY          = 0;
  localparam int SY_SEL          = 1;
  localparam int SY_IO           = 2;
  localparam int SY_ATN          = 3;
  localparam int SY_PAR          = 4;

  // ************************************************************
  // phase machine
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_FREEWT  = 3'b001,
    ST_ARB     = 3'b010,
    ST_WON     = 3'b011,
    ST_LOST    = 3'b100,
    ST_RESP    = 3'b101,
    ST_CONN    = 3'b110
  } sbp_state_t;
endpackage : sbp_pkg

// ===== rtl/sbp_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
// synchronised bus view passed from the input stage to the core
interface sbp_sync_if;
  logic [sbp_pkg::SYNC_W-1:0] ctl;
  logic [sbp_pkg::DB_W-1:0]   db;
  logic                       ctl_chg;
  logic                       db_chg;
  modport src (output ctl, output db, output ctl_chg, output db_chg);
  modport dst (input ctl, input db, input ctl_chg, input db_chg);
endinterface : sbp_sync_if
`default_nettype wire

// ===== rtl/sbp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sbp_sync
(
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  // raw pins
  input  wire logic [sbp_pkg::SYNC_W-1:0] ctl_in,
  input  wire logic [sbp_pkg::DB_W-1:0]   db_in,
  // cleaned view
  sbp_sync_if.src                         so
);
  localparam int W = sbp_pkg::SYNC_W + sbp_pkg::DB_W;

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] agree;

  // ************************************************************
  // three stages, accept once second and third agree
  // ************************************************************
  assign agree = ~(s2_r ^ s3_r);

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end
    else
    begin
      s1_r <= {db_in, ctl_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= (agree & s3_r) | (~agree & q_r);
    end
  end

  // data change flag restarts the selection settle counter in the core; ctl_chg is not used there
  logic [W-1:0] q_nxt;
  assign q_nxt      = (agree & s3_r) | (~agree & q_r);
  assign so.ctl     = q_r[sbp_pkg::SYNC_W-1:0];
  assign so.db      = q_r[W-1:sbp_pkg::SYNC_W];
  assign so.ctl_chg = |(q_nxt[sbp_pkg::SYNC_W-1:0] ^ q_r[sbp_pkg::SYNC_W-1:0]);
  assign so.db_chg  = |(q_nxt[W-1:sbp_pkg::SYNC_W] ^ q_r[W-1:sbp_pkg::SYNC_W]);
endmodule : sbp_sync
`default_nettype wire

// ===== rtl/sbp_cnt.sv
`timescale 1ns/1ps
`default_nettype none
// restartable up-counter, saturating
module sbp_cnt
(
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  // restart
  input  wire logic                       clr,
  // running count
  output logic [sbp_pkg::CNT_W-1:0]       cnt
);
  always_ff @(posedge clk)
  begin
    if (!rst_b || clr)
      cnt <= '0;
    else if (cnt != {sbp_pkg::CNT_W{1'b1}})
      cnt <= cnt + 1'b1;
  end
endmodule : sbp_cnt
`default_nettype wire

// ===== rtl/sbp_phase.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - only one phase at a time; unnamed signals stay released
// - idle seen only after BSY and SEL false continuously a settle delay
// - release all signals within clear delay of idle detection
// - target ends connection by releasing BSY
// - error idle ignores ATN and discards nexus data and status
// - wait a bus free delay after idle before driving anything
// - arbitrate with BSY and own ID, never after bus set delay
// - after arbitration delay sample bus; no higher ID means win, assert SEL
// - losers drop BSY and ID within clear delay of SEL
// - losers hold BSY and ID until SEL is seen
// - started arbitration runs until some winner asserts SEL
// - winner holds signals for clear plus settle after SEL
// - arbitration drives only own ID bit; parity never driven false
// - selected when SEL and own ID true, BSY and I/O false a settle delay
// - assert BSY within selection abort time of last detection
// - ignore selection with bad parity or more than two IDs
// - no REQ until SEL is seen false
// - settle 400 ns minimum, clear 800 ns maximum
// - bus set 1.8 us maximum, bus free 800 ns minimum
// - arbitration delay 2.4 us minimum
// - selection abort 200 us maximum, deskew 400 ns minimum
module sbp_phase
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  // configuration and user requests
  input  wire logic [sbp_pkg::ID_W-1:0]  own_id,
  input  wire logic                      arb_req,
  input  wire logic                      rel_req,
  input  wire logic                      err_rel,
  input  wire logic                      req_in,
  // bus inputs
  input  wire logic                      bsy_in,
  input  wire logic                      sel_in,
  input  wire logic                      io_in,
  input  wire logic                      atn_in,
  input  wire logic [sbp_pkg::DB_W-1:0]  db_in,
  input  wire logic                      dbp_in,
  // bus outputs, enable low while driving
  output logic                           bsy_out,
  output logic                           bsy_oe_b,
  output logic                           sel_out,
  output logic                           sel_oe_b,
  output logic                           req_out,
  output logic                           req_oe_b,
  output logic [sbp_pkg::DB_W-1:0]       db_out,
  output logic [sbp_pkg::DB_W-1:0]       db_oe_b,
  output logic                           dbp_out,
  output logic                           dbp_oe_b,
  // status
  output logic                           bus_free,
  output logic                           arb_won,
  output logic                           arb_lost,
  output logic                           selected,
  output logic [sbp_pkg::DB_W-1:0]       init_ids,
  output logic                           atn_seen,
  output logic                           nexus_flush
);
  // ************************************************************
  // synchronised inputs
  // ************************************************************
  sbp_sync_if sy ();

  sbp_sync u_sync
  (
    .clk    (clk),
    .rst_b  (rst_b),
    .ctl_in ({dbp_in, atn_in, io_in, sel_in, bsy_in}),
    .db_in  (db_in),
    .so     (sy.src)
  );

  wire logic bsy_s = sy.ctl[sbp_pkg::SY_BSY];
  wire logic sel_s = sy.ctl[sbp_pkg::SY_SEL];
  wire logic io_s  = sy.ctl[sbp_pkg::SY_IO];
  wire logic par_s = sy.ctl[sbp_pkg::SY_PAR];

  // ************************************************************
  // decode
  // ************************************************************
  logic [sbp_pkg::DB_W-1:0] own_bit;
  logic [sbp_pkg::DB_W-1:0] higher_mask;
  logic [3:0]               id_count;
  logic                     par_ok;
  logic                     free_cond;
  logic                     sel_cond;
  logic                     sel_valid;

  assign own_bit     = 8'h01 << own_id;
  // bits above own ID win; bit seven is top priority
  assign higher_mask = ~((own_bit << 1) - 8'h01);
  // odd parity over data and parity lines
  assign par_ok      = ^{sy.db, par_s};
  always_comb
  begin
    id_count = 4'h0;
    for (int i = 0; i < sbp_pkg::DB_W; i++)
      id_count = id_count + {3'h0, sy.db[i]};
  end
  assign free_cond = !bsy_s && !sel_s;
  assign sel_cond  = sel_s && !bsy_s && !io_s && ((sy.db & own_bit) != 8'h00);
  // two IDs at most, exactly one other than ours, good parity
  assign sel_valid = sel_cond && par_ok && (id_count == 4'h2);

  // ************************************************************
  // counters; change of condition, or of phase for st_cnt, restarts them
  // ************************************************************
  logic                     free_cond_q;
  logic                     sel_cond_q;
  logic [sbp_pkg::CNT_W-1:0] free_cnt;
  logic [sbp_pkg::CNT_W-1:0] sel_cnt;
  logic [sbp_pkg::CNT_W-1:0] st_cnt;
  logic                     st_clr;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      free_cond_q <= 1'b0;
      sel_cond_q  <= 1'b0;
    end
    else
    begin
      free_cond_q <= free_cond;
      sel_cond_q  <= sel_cond;
    end
  end

  sbp_cnt u_free_cnt
  (
    .clk   (clk),
    .rst_b (rst_b),
    .clr   (!free_cond || !free_cond_q),
    .cnt   (free_cnt)
  );
  sbp_cnt u_sel_cnt
  (
    .clk   (clk),
    .rst_b (rst_b),
    .clr   (!sel_cond || !sel_cond_q || sy.db_chg),
    .cnt   (sel_cnt)
  );
  sbp_cnt u_st_cnt
  (
    .clk   (clk),
    .rst_b (rst_b),
    .clr   (st_clr),
    .cnt   (st_cnt)
  );

  logic free_det;
  logic sel_det;
  assign free_det = free_cnt >= sbp_pkg::CNT_W'(sbp_pkg::SETTLE_CYC);
  assign sel_det  = sel_cnt  >= sbp_pkg::CNT_W'(sbp_pkg::SETTLE_CYC);

  // ************************************************************
  // phase machine
  // ************************************************************
  sbp_pkg::sbp_state_t st_r;
  sbp_pkg::sbp_state_t st_nxt;

  // time measured since idle detection, for free and set delays
  wire logic freewt_done = st_cnt >= sbp_pkg::CNT_W'(sbp_pkg::FREE_CYC);
  wire logic set_late    = st_cnt >  sbp_pkg::CNT_W'(sbp_pkg::SET_CYC);
  wire logic arb_done    = st_cnt >= sbp_pkg::CNT_W'(sbp_pkg::ARB_CYC);
  wire logic hold_done   = st_cnt >= sbp_pkg::CNT_W'(sbp_pkg::HOLD_CYC);
  wire logic lost_now    = (sy.db & higher_mask) != 8'h00;

  always_comb
  begin
    st_nxt = st_r;
    st_clr = 1'b0;
    case (st_r)
      sbp_pkg::ST_IDLE:
      begin
        st_clr = 1'b1;
        if (sel_det && sel_valid)
          st_nxt = sbp_pkg::ST_RESP;
        else if (free_det)
          st_nxt = sbp_pkg::ST_FREEWT;
      end
      sbp_pkg::ST_FREEWT:
      begin
        // leaving idle, or missing the set window without arb_req, returns to idle; a late arb_req waits here
        if (!free_cond || (set_late && !arb_req))
        begin
          st_nxt = sbp_pkg::ST_IDLE;
          st_clr = 1'b1;
        end
        else if (arb_req && freewt_done && !set_late)
        begin
          st_nxt = sbp_pkg::ST_ARB;
          st_clr = 1'b1;
        end
      end
      sbp_pkg::ST_ARB:
      begin
        // started arbitration is carried to some SEL
        if (sel_s)
        begin
          st_nxt = sbp_pkg::ST_LOST;
          st_clr = 1'b1;
        end
        else if (arb_done)
        begin
          st_clr = 1'b1;
          st_nxt = lost_now ? sbp_pkg::ST_LOST : sbp_pkg::ST_WON;
        end
      end
      sbp_pkg::ST_WON:
      begin
        // initiator role is outside this block; hold then give way
        if (hold_done)
        begin
          st_nxt = sbp_pkg::ST_IDLE;
          st_clr = 1'b1;
        end
      end
      sbp_pkg::ST_LOST:
      begin
        // keep BSY and ID until SEL is seen, then release
        if (sel_s)
        begin
          st_nxt = sbp_pkg::ST_IDLE;
          st_clr = 1'b1;
        end
      end
      sbp_pkg::ST_RESP:
      begin
        st_nxt = sbp_pkg::ST_CONN;
        st_clr = 1'b1;
      end
      sbp_pkg::ST_CONN:
      begin
        if (rel_req || err_rel)
        begin
          st_nxt = sbp_pkg::ST_IDLE;
          st_clr = 1'b1;
        end
      end
      default:
      begin
        st_nxt = sbp_pkg::ST_IDLE;
        st_clr = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      st_r <= sbp_pkg::ST_IDLE;
    else
      st_r <= st_nxt;
  end

  // ************************************************************
  // pin drivers and status, all registered
  // ************************************************************
  logic drive_bsy;
  logic drive_sel;
  logic drive_id;
  logic drive_req;

  assign drive_bsy = (st_nxt == sbp_pkg::ST_ARB) || (st_nxt == sbp_pkg::ST_WON)
                  || (st_nxt == sbp_pkg::ST_LOST) || (st_nxt == sbp_pkg::ST_CONN);
  assign drive_sel = (st_nxt == sbp_pkg::ST_WON);
  assign drive_id  = (st_nxt == sbp_pkg::ST_ARB) || (st_nxt == sbp_pkg::ST_WON)
                  || (st_nxt == sbp_pkg::ST_LOST);
  // REQ only once SEL has gone away in the connection
  assign drive_req = (st_nxt == sbp_pkg::ST_CONN) && req_in && !sel_s;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      bsy_out     <= 1'b0;
      bsy_oe_b    <= 1'b1;
      sel_out     <= 1'b0;
      sel_oe_b    <= 1'b1;
      req_out     <= 1'b0;
      req_oe_b    <= 1'b1;
      db_out      <= 8'h00;
      db_oe_b     <= 8'hFF;
      dbp_out     <= 1'b0;
      dbp_oe_b    <= 1'b1;
      bus_free    <= 1'b0;
      arb_won     <= 1'b0;
      arb_lost    <= 1'b0;
      selected    <= 1'b0;
      init_ids    <= 8'h00;
      atn_seen    <= 1'b0;
      nexus_flush <= 1'b0;
    end
    else
    begin
      // everything not driven is released, incl. during idle
      bsy_out     <= drive_bsy;
      bsy_oe_b    <= !drive_bsy;
      sel_out     <= drive_sel;
      sel_oe_b    <= !drive_sel;
      req_out     <= drive_req;
      req_oe_b    <= !drive_req;
      db_out      <= drive_id ? own_bit : 8'h00;
      db_oe_b     <= drive_id ? ~own_bit : 8'hFF;
      // parity left released: never driven false in arbitration
      dbp_out     <= 1'b0;
      dbp_oe_b    <= 1'b1;
      bus_free    <= free_det;
      arb_won     <= (st_nxt == sbp_pkg::ST_WON);
      arb_lost    <= (st_nxt == sbp_pkg::ST_LOST);
      selected    <= (st_nxt == sbp_pkg::ST_CONN);
      init_ids    <= (st_r == sbp_pkg::ST_IDLE && st_nxt == sbp_pkg::ST_RESP)
                     ? (sy.db & ~own_bit) : init_ids;
      atn_seen    <= (st_r == sbp_pkg::ST_IDLE && st_nxt == sbp_pkg::ST_RESP)
                     ? sy.ctl[sbp_pkg::SY_ATN] : atn_seen;
      // error release ignores ATN and flushes the nexus
      nexus_flush <= (st_r == sbp_pkg::ST_CONN) && err_rel;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_sel_in_resp;
    st_r == sbp_pkg::ST_RESP;
  endsequence

  a_free_settle: assert property ((st_r == sbp_pkg::ST_FREEWT && $past(st_r) == sbp_pkg::ST_IDLE)
    |-> $past(free_cnt) >= sbp_pkg::CNT_W'(sbp_pkg::SETTLE_CYC)) else $error("idle taken early");
  a_idle_release: assert property (st_r == sbp_pkg::ST_FREEWT |-> bsy_oe_b && sel_oe_b && (&db_oe_b))
    else $error("bus driven in idle");
  a_free_wait: assert property ($rose(st_r == sbp_pkg::ST_ARB)
    |-> $past(st_cnt) >= sbp_pkg::CNT_W'(sbp_pkg::FREE_CYC)) else $error("arbitrated too soon");
  a_set_window: assert property ($rose(st_r == sbp_pkg::ST_ARB)
    |-> $past(st_cnt) <= sbp_pkg::CNT_W'(sbp_pkg::SET_CYC)) else $error("arbitrated too late");
  a_arb_delay: assert property ((st_r == sbp_pkg::ST_ARB && st_nxt == sbp_pkg::ST_WON)
    |-> st_cnt >= sbp_pkg::CNT_W'(sbp_pkg::ARB_CYC)) else $error("sampled too soon");
  a_lose_hold: assert property (st_r == sbp_pkg::ST_LOST && !sel_s |=> !bsy_oe_b)
    else $error("loser released before SEL");
  a_win_hold: assert property ($rose(st_r == sbp_pkg::ST_WON)
    |=> (!sel_oe_b && !bsy_oe_b)[*8]) else $error("winner changed signals");
  a_id_only: assert property (!bsy_oe_b && st_r != sbp_pkg::ST_CONN |-> db_oe_b == ~own_bit)
    else $error("other data bits driven");
  a_bsy_resp: assert property (s_sel_in_resp |=> !bsy_oe_b) else $error("no BSY response");
  a_req_gate: assert property (!req_oe_b |-> $past(!sel_s)) else $error("REQ with SEL true");
  a_bad_sel: assert property ((st_r == sbp_pkg::ST_IDLE && !sel_valid) |=> st_r != sbp_pkg::ST_RESP)
    else $error("bad selection taken");
endmodule : sbp_phase
`default_nettype wire

// ===== tb/sbp_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// far side: rival arbiter or selecting initiator
// ************************************************************
// released lines read false, as the terminators pull them to the negated level
module sbp_bus_model
(
  // clock and wired bus view
  input  wire logic       clk,
  input  wire logic       bsy_bus,
  // far-side drive, true = asserted
  output logic            p_bsy,
  output logic            p_sel,
  output logic            p_atn,
  output logic [7:0]      p_db,
  output logic            p_dbp
);
  initial
    {p_bsy, p_sel, p_atn, p_db, p_dbp} = '0;

  // arbitrate with BSY and one ID bit only, parity left released
  task automatic arb(input logic [7:0] id_bit);
    @(negedge clk);
    p_bsy = 1'b1;
    p_db  = id_bit;
  endtask : arb

  // winner of arbitration asserts SEL
  task automatic take_sel;
    @(negedge clk);
    p_sel = 1'b1;
  endtask : take_sel

  // release every line
  task automatic drop;
    @(negedge clk);
    {p_bsy, p_sel, p_atn, p_db, p_dbp} = '0;
  endtask : drop

  // selection; I/O is not driven here but left to the testbench, the wait for BSY is shortened
  task automatic select(input logic [7:0] ids, input logic par_ok);
    int n;
    @(negedge clk);
    p_bsy = 1'b1;
    p_sel = 1'b1;
    p_atn = 1'b1;
    p_db  = ids;
    p_dbp = (~^ids) ^ ~par_ok;
    repeat (2 * sbp_pkg::DESKEW_CYC) @(negedge clk);
    p_bsy = 1'b0;
    repeat (sbp_pkg::SETTLE_CYC) @(negedge clk);
    for (n = 0; n < 300 && bsy_bus !== 1'b1; n++) @(negedge clk);
    if (n < 300)
    begin
      repeat (2 * sbp_pkg::DESKEW_CYC) @(negedge clk);
      p_sel = 1'b0;
      p_db  = 8'h00;
      p_dbp = 1'b0;
    end
    else
      drop();
  endtask : select
endmodule : sbp_bus_model
`default_nettype wire

// ===== tb/bus_free_arbitration_selection_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bus_free_arbitration_selection_tb;
  // ************************************************************
  // clock, reset and wired bus
  // ************************************************************
  localparam int ST = sbp_pkg::SETTLE_CYC;
  localparam int DK = sbp_pkg::DESKEW_CYC;
  logic       clk, rst_b, arb_req, rel_req, err_rel, req_in;
  logic [2:0] own_id;
  logic       bsy_out, bsy_oe_b, sel_out, sel_oe_b, req_out, req_oe_b;
  logic [7:0] db_out, db_oe_b, init_ids, p_db;
  logic       dbp_out, dbp_oe_b, bus_free, arb_won, arb_lost, selected;
  logic       atn_seen, nexus_flush, p_bsy, p_sel, p_atn, p_dbp, bad, io_drv;
  int         err_total, checked, cyc, n;
  // wired-OR of both parties, enables active low
  wire logic       bsy_w = p_bsy | (~bsy_oe_b & bsy_out);
  wire logic       sel_w = p_sel | (~sel_oe_b & sel_out);
  wire logic [7:0] db_w  = p_db | (~db_oe_b & db_out);
  wire logic       dbp_w = p_dbp | (~dbp_oe_b & dbp_out);

  sbp_phase uut
  (
    .clk(clk), .rst_b(rst_b), .own_id(own_id), .arb_req(arb_req), .rel_req(rel_req),
    .err_rel(err_rel), .req_in(req_in), .bsy_in(bsy_w), .sel_in(sel_w), .io_in(io_drv),
    .atn_in(p_atn), .db_in(db_w), .dbp_in(dbp_w), .bsy_out(bsy_out), .bsy_oe_b(bsy_oe_b),
    .sel_out(sel_out), .sel_oe_b(sel_oe_b), .req_out(req_out), .req_oe_b(req_oe_b),
    .db_out(db_out), .db_oe_b(db_oe_b), .dbp_out(dbp_out), .dbp_oe_b(dbp_oe_b),
    .bus_free(bus_free), .arb_won(arb_won), .arb_lost(arb_lost), .selected(selected),
    .init_ids(init_ids), .atn_seen(atn_seen), .nexus_flush(nexus_flush)
  );

  sbp_bus_model model
  (
    .clk(clk), .bsy_bus(bsy_w), .p_bsy(p_bsy), .p_sel(p_sel), .p_atn(p_atn),
    .p_db(p_db), .p_dbp(p_dbp)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // hang guard, the whole run needs a few thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      stop_test();
    end
  end

  // ************************************************************
  // compare and closing tasks
  // ************************************************************
  task automatic chk_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_byte

  task automatic stop_test;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // ************************************************************
  // scenarios
  // ************************************************************
  // a short BSY glitch must restart the settle count
  task automatic t_idle;
    model.arb(8'h00);
    repeat (10) @(negedge clk);
    model.drop();
    repeat (30) @(negedge clk);
    // three cycles, long enough to pass the input filter
    model.arb(8'h00);
    repeat (2) @(negedge clk);
    model.drop();
    for (n = 0; n < 100 && bus_free !== 1'b1; n++) @(negedge clk);
    chk_bit("idle settle", 1'b1, n >= ST && n <= ST + 8);
    chk_bit("idle settle", 1'b1, n >= ST && n <= ST + 8);
  endtask : t_idle

  // rival with a lower ID; this side wins and holds SEL and BSY
  task automatic t_win;
    arb_req = 1'b1;
    model.arb(8'h00);
    repeat (2) @(negedge clk);
    model.drop();
    for (n = 0; n < 400 && bsy_oe_b !== 1'b0; n++) @(negedge clk);
    chk_bit("arb start", 1'b1, n >= ST + sbp_pkg::FREE_CYC);
    chk_bit("arb start", 1'b1, n <= ST + sbp_pkg::SET_CYC + 8);
    model.arb(8'h04);
    chk_byte("arb id enable", 8'hF7, db_oe_b);
    chk_bit("parity enable", 1'b1, dbp_oe_b);
    for (n = 0; n < 400 && sel_oe_b !== 1'b0; n++) @(negedge clk);
    chk_bit("arb delay", 1'b1, n >= sbp_pkg::ARB_CYC - 2 && n <= sbp_pkg::ARB_CYC + 10);
    chk_bit("arb won", 1'b1, arb_won);
    repeat (20) @(negedge clk);
    model.drop();
    for (n = 0; n < 400 && sel_oe_b === 1'b0 && bsy_oe_b === 1'b0; n++) @(negedge clk);
    chk_bit("winner hold", 1'b1, n >= sbp_pkg::HOLD_CYC - 22);
    arb_req = 1'b0;
    repeat (4) @(negedge clk);
    chk_byte("released", 8'hFF, db_oe_b);
  endtask : t_win

  // rival with a higher ID; loser keeps BSY until SEL, then clears in time
  task automatic t_lose;
    arb_req = 1'b1;
    model.arb(8'h00);
    repeat (2) @(negedge clk);
    model.drop();
    for (n = 0; n < 400 && bsy_oe_b !== 1'b0; n++) @(negedge clk);
    model.arb(8'h20);
    for (n = 0; n < 400 && arb_lost !== 1'b1; n++) @(negedge clk);
    chk_bit("arb lost", 1'b1, arb_lost);
    repeat (20) @(negedge clk);
    chk_bit("loser holds", 1'b0, bsy_oe_b);
    model.take_sel();
    for (n = 0; n < 200 && (bsy_oe_b !== 1'b1 || db_oe_b !== 8'hFF); n++) @(negedge clk);
    chk_bit("loser clear", 1'b1, n <= sbp_pkg::CLEAR_CYC);
    arb_req = 1'b0;
    model.drop();
    repeat (100) @(negedge clk);
  endtask : t_lose

  // valid selection, REQ held back until SEL false, then normal or error end
  task automatic t_sel(input logic use_err);
    bad = 1'b0;
    req_in = 1'b1;
    own_id = use_err ? 3'h6 : 3'h3;
    io_drv = 1'b0;
    fork
      model.select(8'h48, 1'b1);
      begin
        for (n = 0; n < 3 * DK + ST + 20 && selected !== 1'b1; n++) @(negedge clk);
        repeat (2) @(negedge clk);
        chk_bit("bsy answer", 1'b0, bsy_oe_b);
        chk_byte("initiator id", use_err ? 8'h08 : 8'h40, init_ids);
        chk_bit("atn seen", 1'b1, atn_seen);
        while (sel_w === 1'b1)
        begin
          bad = bad | (req_oe_b !== 1'b1);
          @(negedge clk);
        end
      end
    join
    chk_bit("req held back", 1'b0, bad);
    for (n = 0; n < 10 && req_oe_b !== 1'b0; n++) @(negedge clk);
    chk_bit("req driven", 1'b0, req_oe_b);
    req_in = 1'b0;
    rel_req = ~use_err;
    err_rel = use_err;
    n = 0;
    repeat (10)
    begin
      @(negedge clk);
      n = n + (nexus_flush === 1'b1);
    end
    chk_bit("flush pulse", use_err, n == 1);
    chk_bit("bsy released", 1'b1, bsy_oe_b);
    rel_req = 1'b0;
    err_rel = 1'b0;
    model.drop();
    repeat (100) @(negedge clk);
  endtask : t_sel

  // bad parity, three ID bits, then I/O asserted: no answer at all
  task automatic t_bad;
    logic [7:0] ids[3];
    ids = '{8'h48, 8'h4C, 8'h48};
    for (int i = 0; i < 3; i++)
    begin
      bad = 1'b0;
      io_drv = (i == 2);
      fork
        model.select(ids[i], i != 0);
        repeat (2 * DK + 300)
        begin
          @(negedge clk);
          bad = bad | (selected === 1'b1) | (bsy_oe_b !== 1'b1);
        end
      join
      chk_bit("ignored select", 1'b0, bad);
    end
    io_drv = 1'b0;
  endtask : t_bad

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    {rst_b, arb_req, rel_req, err_rel, req_in, io_drv} = '0;
    own_id = 3'h3;
    err_total = 0;
    checked = 0;
    cyc = 0;
    repeat (16) @(negedge clk);
    chk_byte("reset enables", 8'hFF, db_oe_b);
    chk_bit("reset bsy enable", 1'b1, bsy_oe_b);
    rst_b = 1'b1;
    t_idle();
    t_win();
    t_lose();
    t_sel(1'b0);
    t_sel(1'b1);
    t_bad();
    stop_test();
  end
endmodule : bus_free_arbitration_selection_tb
`default_nettype wire
